/* srs_pkg.sv */
package srs_pkg;
	localparam int unsigned SRS_CLK_HZ = 50_000_000;

	localparam logic [31:0] SRS_OFS_CTL = 32'h0000_0000;
	localparam logic [31:0] SRS_OFS_STAT = 32'h0000_0004;
	localparam logic [31:0] SRS_OFS_STRAP = 32'h0000_0008;
	localparam logic [31:0] SRS_OFS_ADDR_MASK = 32'h0000_00FC;

	localparam int SRS_CTL_HALT_BIT = 0;
	localparam logic SRS_CTL_HALT_RST = 1'b0;

	localparam int SRS_STAT_STATE_LSB = 0;
	localparam int SRS_STAT_HOLD_SEEN_BIT = 2;
	localparam int SRS_STAT_SMB_BIT = 3;
	localparam int SRS_STAT_CORE_BIT = 4;
	localparam int SRS_STAT_BADMODE_BIT = 5;

	localparam int SRS_STRAP_MODE_LSB = 0;
	localparam int SRS_STRAP_FSEL_BIT = 4;
	localparam int SRS_STRAP_CLKM_LSB = 5;
	localparam int SRS_STRAP_STK2_LSB = 8;
	localparam int SRS_STRAP_STK3_LSB = 12;
	localparam int SRS_STRAP_SADDR_LSB = 17;

	localparam logic [1:0] SRS_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] SRS_HRESP_OKAY = 2'h0;
	localparam logic [31:0] SRS_RDATA_ZERO = 32'h0000_0000;

	localparam logic [3:0] SRS_MODE_SP = 4'h0;
	localparam logic [3:0] SRS_MODE_SP_EE = 4'h1;
	localparam logic [3:0] SRS_MODE_SP_JUMP0 = 4'h2;
	localparam logic [3:0] SRS_MODE_SP_JUMP1 = 4'h3;
	localparam logic [3:0] SRS_MODE_RSVD_LO = 4'h4;
	localparam logic [3:0] SRS_MODE_RSVD_HI = 4'h7;
	localparam logic [3:0] SRS_MODE_MP_UNATT = 4'hA;
	localparam logic [3:0] SRS_MODE_MP_UNATT_EE = 4'hB;
	localparam logic [3:0] SRS_MODE_MP_UNATT_I2C = 4'hC;
	localparam logic [3:0] SRS_MODE_MP_DIS_EE = 4'hF;

	localparam logic [1:0] SRS_JUMP_NONE = 2'h0;
	localparam logic [1:0] SRS_JUMP_0 = 2'h1;
	localparam logic [1:0] SRS_JUMP_1 = 2'h2;

	localparam logic [6:0] SRS_SMB_ADDR_BASE = 7'h50;
	localparam int SRS_SMB_ADDR_LO = 1;

	localparam int unsigned SRS_REFCLK_LO_MHZ = 100;
	localparam int unsigned SRS_REFCLK_HI_MHZ = 125;

	typedef enum logic [1:0] {
		SRS_ST_RESET = 2'b00,
		SRS_ST_QUASI = 2'b01,
		SRS_ST_RUN = 2'b11
	} srs_state_t;
endpackage

/* srs_strap_latch.sv */
`timescale 1ns/10ps
`default_nettype none
module srs_strap_latch
	import srs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic core_in_reset,
	input wire logic capture,
	input wire logic [3:0] switch_operating_mode,
	input wire logic refclk_freq_select,
	input wire logic [1:0] port_clocking_select,
	input wire logic [3:0] stack2_lane_config,
	input wire logic [4:0] stack3_lane_config,
	input wire logic [1:0] slave_smbus_addr_straps,
	output logic [3:0] mode_code,
	output logic refclk_125_sel,
	output logic [1:0] port_clk_mode,
	output logic [3:0] stack2_cfg,
	output logic [4:0] stack3_cfg,
	output logic [6:0] smbus_slave_addr,
	output logic multi_partition,
	output logic init_from_eeprom,
	output logic [1:0] eeprom_jump,
	output logic ports_unattached,
	output logic i2c_reset_init,
	output logic mode_invalid
);
	logic [3:0] mode_r, mode_nxt;
	logic fsel_r, fsel_nxt;
	logic [1:0] clkm_r, clkm_nxt;
	logic [3:0] stk2_r, stk2_nxt;
	logic [4:0] stk3_r, stk3_nxt;
	logic [1:0] saddr_r, saddr_nxt;
	logic multi_r, multi_nxt;
	logic ee_r, ee_nxt;
	logic [1:0] jump_r, jump_nxt;
	logic unatt_r, unatt_nxt;
	logic i2c_r, i2c_nxt;
	logic bad_r, bad_nxt;

	always_comb begin
		mode_nxt = mode_r;
		fsel_nxt = fsel_r;
		clkm_nxt = clkm_r;
		stk2_nxt = stk2_r;
		stk3_nxt = stk3_r;
		saddr_nxt = saddr_r;
		multi_nxt = multi_r;
		ee_nxt = ee_r;
		jump_nxt = jump_r;
		unatt_nxt = unatt_r;
		i2c_nxt = i2c_r;
		bad_nxt = bad_r;
		if (core_in_reset) begin
			// whole strap image held cleared under fundamental reset [R01]
			mode_nxt = 4'h0;
			fsel_nxt = 1'b0;
			clkm_nxt = 2'h0;
			stk2_nxt = 4'h0;
			stk3_nxt = 5'h00;
			saddr_nxt = 2'h0;
			multi_nxt = 1'b0;
			ee_nxt = 1'b0;
			jump_nxt = SRS_JUMP_NONE;
			unatt_nxt = 1'b0;
			i2c_nxt = 1'b0;
			bad_nxt = 1'b0;
		end else if (capture) begin
			// one snapshot at release, later strap moves ignored [R16]
			mode_nxt = switch_operating_mode;
			fsel_nxt = refclk_freq_select; // [R11] [R15]
			clkm_nxt = port_clocking_select; // [R12]
			stk2_nxt = stack2_lane_config; // [R13]
			stk3_nxt = stack3_lane_config; // [R13]
			saddr_nxt = slave_smbus_addr_straps; // [R14]
			multi_nxt = 1'b0;
			ee_nxt = 1'b0;
			jump_nxt = SRS_JUMP_NONE;
			unatt_nxt = 1'b0;
			i2c_nxt = 1'b0;
			bad_nxt = 1'b0;
			unique case (switch_operating_mode)
				SRS_MODE_SP: begin
				end
				SRS_MODE_SP_EE: ee_nxt = 1'b1; // [R06]
				SRS_MODE_SP_JUMP0: begin
					ee_nxt = 1'b1;
					jump_nxt = SRS_JUMP_0; // [R07]
				end
				SRS_MODE_SP_JUMP1: begin
					ee_nxt = 1'b1;
					jump_nxt = SRS_JUMP_1; // [R07]
				end
				SRS_MODE_MP_UNATT: begin
					multi_nxt = 1'b1;
					unatt_nxt = 1'b1; // [R10]
				end
				SRS_MODE_MP_UNATT_EE: begin
					multi_nxt = 1'b1;
					unatt_nxt = 1'b1;
					ee_nxt = 1'b1; // [R10]
				end
				SRS_MODE_MP_UNATT_I2C: begin
					multi_nxt = 1'b1;
					unatt_nxt = 1'b1;
					ee_nxt = 1'b1;
					i2c_nxt = 1'b1; // [R10]
				end
				SRS_MODE_MP_DIS_EE: begin
					multi_nxt = 1'b1;
					ee_nxt = 1'b1; // [R09]
				end
				// reserved and unsupported codes flagged, fall back to plain single [R08]
				default: bad_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mode_r <= 4'h0;
			fsel_r <= 1'b0;
			clkm_r <= 2'h0;
			stk2_r <= 4'h0;
			stk3_r <= 5'h00;
			saddr_r <= 2'h0;
			multi_r <= 1'b0;
			ee_r <= 1'b0;
			jump_r <= SRS_JUMP_NONE;
			unatt_r <= 1'b0;
			i2c_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			fsel_r <= fsel_nxt;
			clkm_r <= clkm_nxt;
			stk2_r <= stk2_nxt;
			stk3_r <= stk3_nxt;
			saddr_r <= saddr_nxt;
			multi_r <= multi_nxt;
			ee_r <= ee_nxt;
			jump_r <= jump_nxt;
			unatt_r <= unatt_nxt;
			i2c_r <= i2c_nxt;
			bad_r <= bad_nxt;
		end
	end

	assign mode_code = mode_r;
	assign refclk_125_sel = fsel_r;
	assign port_clk_mode = clkm_r;
	assign stack2_cfg = stk2_r;
	assign stack3_cfg = stk3_r;
	always_comb begin
		smbus_slave_addr = SRS_SMB_ADDR_BASE;
		smbus_slave_addr[SRS_SMB_ADDR_LO +: 2] = saddr_r; // [R14]
	end
	assign multi_partition = multi_r;
	assign init_from_eeprom = ee_r;
	assign eeprom_jump = jump_r;
	assign ports_unattached = unatt_r;
	assign i2c_reset_init = i2c_r;
	assign mode_invalid = bad_r;
endmodule
`default_nettype wire

/* srs_reset_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R01: fundamental reset low holds all internal logic in reset; here the bus slave still serves reads and hold_seen_r still records.
// R02: hold request seen during reset parks device in quasi-reset, SMBus alive.
// R03: in quasi-reset, registers stay readable and writable over the bus.
// R04: clearing the hold bit in switch control releases normal operation.
// R05: board keeps operating mode straps static after reset release.
// R06: mode 0x0 single partition plain; 0x1 single partition with EEPROM init.
// R07: mode 0x2 single partition EEPROM jump 0; 0x3 jump 1.
// R08: modes 0x4 to 0x7 reserved, board must not strap them.
// R09: mode 0xF multi-partition, unassigned ports disabled, EEPROM init.
// R10: multi-partition unattached modes: plain, EEPROM, I2C reset plus EEPROM.
// R11: frequency select 0 means 100 MHz reference, 1 means 125 MHz.
// R12: two-bit clock mode strap picks the port clocking mode.
// R13: four-bit strap configures stack 2, five-bit strap stack 3.
// R14: slave SMBus address partly set by slave address straps.
// R15: PLLs use global reference with the strap-selected frequency.
// R16: straps captured at reset release, ignored until next reset.
module srs_reset_ctrl
	import srs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic fundamental_reset_n,
	input wire logic reset_hold_request,
	input wire logic [3:0] switch_operating_mode,
	input wire logic refclk_freq_select,
	input wire logic [1:0] port_clocking_select,
	input wire logic [3:0] stack2_lane_config,
	input wire logic [4:0] stack3_lane_config,
	input wire logic [1:0] slave_smbus_addr_straps,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic core_reset_n,
	output logic smbus_active,
	output logic refclk_125_sel,
	output logic [1:0] port_clk_mode,
	output logic [3:0] stack2_cfg,
	output logic [4:0] stack3_cfg,
	output logic [6:0] smbus_slave_addr,
	output logic multi_partition,
	output logic init_from_eeprom,
	output logic [1:0] eeprom_jump,
	output logic ports_unattached,
	output logic i2c_reset_init,
	output logic mode_invalid
);
	srs_state_t st_r, st_nxt;
	logic prev_fund_r, prev_fund_nxt;
	logic hold_seen_r, hold_seen_nxt;
	logic halt_r, halt_nxt;
	logic core_r, core_nxt;
	logic smb_r, smb_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [31:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] mode_code;
	logic release_evt;
	logic addr_take;
	logic ctl_wr_clear;
	logic [31:0] stat_word;
	logic [31:0] strap_word;

	// hsize is accepted as given: only whole-word transfers reach this slave
	assign addr_take = hsel && hready && htrans == SRS_HTRANS_NONSEQ;
	assign release_evt = fundamental_reset_n && !prev_fund_r;
	assign ctl_wr_clear = wr_pend_r && wr_addr_r == SRS_OFS_CTL && !hwdata[SRS_CTL_HALT_BIT];

	srs_strap_latch u_latch (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.core_in_reset(!fundamental_reset_n),
		.capture(release_evt),
		.switch_operating_mode(switch_operating_mode), // [R05]
		.refclk_freq_select(refclk_freq_select),
		.port_clocking_select(port_clocking_select),
		.stack2_lane_config(stack2_lane_config),
		.stack3_lane_config(stack3_lane_config),
		.slave_smbus_addr_straps(slave_smbus_addr_straps),
		.mode_code(mode_code),
		.refclk_125_sel(refclk_125_sel),
		.port_clk_mode(port_clk_mode),
		.stack2_cfg(stack2_cfg),
		.stack3_cfg(stack3_cfg),
		.smbus_slave_addr(smbus_slave_addr),
		.multi_partition(multi_partition),
		.init_from_eeprom(init_from_eeprom),
		.eeprom_jump(eeprom_jump),
		.ports_unattached(ports_unattached),
		.i2c_reset_init(i2c_reset_init),
		.mode_invalid(mode_invalid)
	);

	always_comb begin
		st_nxt = st_r;
		prev_fund_nxt = fundamental_reset_n;
		hold_seen_nxt = hold_seen_r;
		halt_nxt = halt_r;
		if (!fundamental_reset_n) begin
			st_nxt = SRS_ST_RESET; // [R01]
			halt_nxt = SRS_CTL_HALT_RST;
			// any hold request during the reset sequence is remembered [R02]
			hold_seen_nxt = hold_seen_r || reset_hold_request;
		end else begin
			unique case (st_r)
				SRS_ST_RESET: begin
					if (hold_seen_r || reset_hold_request) begin
						st_nxt = SRS_ST_QUASI; // [R02]
						halt_nxt = 1'b1;
					end else begin
						st_nxt = SRS_ST_RUN;
					end
					hold_seen_nxt = 1'b0;
				end
				SRS_ST_QUASI: begin
					// apart from fundamental reset, a software write of zero is the only way out [R04]
					if (ctl_wr_clear) begin
						halt_nxt = 1'b0;
					end
					if (!halt_r) begin
						st_nxt = SRS_ST_RUN; // [R04]
					end
				end
				SRS_ST_RUN: begin
					if (ctl_wr_clear) begin
						halt_nxt = 1'b0;
					end
				end
				default: st_nxt = SRS_ST_RESET;
			endcase
		end
		core_nxt = st_nxt == SRS_ST_RUN; // [R01] [R02]
		smb_nxt = st_nxt != SRS_ST_RESET; // [R02]
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_r <= SRS_ST_RESET;
			prev_fund_r <= 1'b0;
			hold_seen_r <= 1'b0;
			halt_r <= SRS_CTL_HALT_RST;
			core_r <= 1'b0;
			smb_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			prev_fund_r <= prev_fund_nxt;
			hold_seen_r <= hold_seen_nxt;
			halt_r <= halt_nxt;
			core_r <= core_nxt;
			smb_r <= smb_nxt;
		end
	end

	always_comb begin
		stat_word = SRS_RDATA_ZERO;
		stat_word[SRS_STAT_STATE_LSB +: 2] = st_r;
		stat_word[SRS_STAT_HOLD_SEEN_BIT] = hold_seen_r;
		stat_word[SRS_STAT_SMB_BIT] = smb_r;
		stat_word[SRS_STAT_CORE_BIT] = core_r;
		stat_word[SRS_STAT_BADMODE_BIT] = mode_invalid; // [R08]
		strap_word = SRS_RDATA_ZERO;
		strap_word[SRS_STRAP_MODE_LSB +: 4] = mode_code;
		strap_word[SRS_STRAP_FSEL_BIT] = refclk_125_sel;
		strap_word[SRS_STRAP_CLKM_LSB +: 2] = port_clk_mode;
		strap_word[SRS_STRAP_STK2_LSB +: 4] = stack2_cfg;
		strap_word[SRS_STRAP_STK3_LSB +: 5] = stack3_cfg;
		strap_word[SRS_STRAP_SADDR_LSB +: 2] = smbus_slave_addr[SRS_SMB_ADDR_LO +: 2];
	end

	// zero-wait slave: read data registered at the address phase edge
	always_comb begin
		wr_pend_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		rdata_nxt = rdata_r;
		if (addr_take) begin
			wr_pend_nxt = hwrite;
			wr_addr_nxt = haddr & SRS_OFS_ADDR_MASK;
			rdata_nxt = SRS_RDATA_ZERO;
			if (!hwrite) begin
				// bus stays live in quasi-reset for setup software [R03]
				unique case (haddr & SRS_OFS_ADDR_MASK)
					SRS_OFS_CTL: rdata_nxt[SRS_CTL_HALT_BIT] = halt_r;
					SRS_OFS_STAT: rdata_nxt = stat_word;
					SRS_OFS_STRAP: rdata_nxt = strap_word;
					default: rdata_nxt = SRS_RDATA_ZERO;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 32'h0000_0000;
			rdata_r <= SRS_RDATA_ZERO;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = SRS_HRESP_OKAY[0];
	assign hrdata = rdata_r;
	assign core_reset_n = core_r;
	assign smbus_active = smb_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_release_held;
		!fundamental_reset_n ##1 fundamental_reset_n && (hold_seen_r || reset_hold_request);
	endsequence
	sequence s_release_free;
		!fundamental_reset_n && !hold_seen_r && !reset_hold_request
			##1 fundamental_reset_n && !reset_hold_request;
	endsequence

	a_reset_holds_core: assert property ( // [R01]
		!fundamental_reset_n |=> !core_reset_n && !smbus_active && st_r == SRS_ST_RESET)
		else $error("core left reset while fundamental reset low");
	a_halt_parks_quasi: assert property ( // [R02]
		s_release_held |=> st_r == SRS_ST_QUASI && smbus_active && !core_reset_n && halt_r)
		else $error("hold request did not park device in quasi-reset");
	a_free_release_runs: assert property ( // [R02]
		s_release_free |=> st_r == SRS_ST_RUN && core_reset_n && smbus_active)
		else $error("release without hold did not start normal operation");
	a_quasi_bus_write: assert property ( // [R03]
		st_r == SRS_ST_QUASI && fundamental_reset_n && ctl_wr_clear |=> !halt_r)
		else $error("write in quasi-reset did not reach switch control");
	a_clear_exits_quasi: assert property ( // [R04]
		st_r == SRS_ST_QUASI && halt_r && fundamental_reset_n ##1
		ctl_wr_clear && fundamental_reset_n ##1 fundamental_reset_n |=> core_reset_n)
		else $error("clearing hold bit did not release device");
	a_quasi_stays: assert property ( // [R04]
		st_r == SRS_ST_QUASI && halt_r && fundamental_reset_n && !ctl_wr_clear
		|=> st_r == SRS_ST_QUASI)
		else $error("quasi-reset left without software clear");
	a_straps_frozen: assert property ( // [R16]
		fundamental_reset_n && $past(fundamental_reset_n) && prev_fund_r
		|=> $stable(strap_word) && $stable(multi_partition) && $stable(eeprom_jump))
		else $error("strap image changed after capture");
	a_capture_takes: assert property ( // [R16]
		release_evt |=> mode_code == $past(switch_operating_mode)
		&& stack3_cfg == $past(stack3_lane_config))
		else $error("straps not captured at release");
	a_mode_single: assert property ( // [R06]
		release_evt && switch_operating_mode == SRS_MODE_SP_EE
		|=> init_from_eeprom && !multi_partition && eeprom_jump == SRS_JUMP_NONE)
		else $error("mode one decoded wrong");
	a_mode_jump: assert property ( // [R07]
		release_evt && switch_operating_mode == SRS_MODE_SP_JUMP1
		|=> eeprom_jump == SRS_JUMP_1 && !multi_partition)
		else $error("jump mode decoded wrong");
	a_mode_reserved: assert property ( // [R08]
		release_evt && switch_operating_mode >= SRS_MODE_RSVD_LO
		&& switch_operating_mode <= SRS_MODE_RSVD_HI |=> mode_invalid && !multi_partition)
		else $error("reserved mode not flagged");
	a_mode_multi_dis: assert property ( // [R09]
		release_evt && switch_operating_mode == SRS_MODE_MP_DIS_EE
		|=> multi_partition && init_from_eeprom && !ports_unattached)
		else $error("multi-partition disabled mode decoded wrong");
	a_mode_i2c: assert property ( // [R10]
		release_evt && switch_operating_mode == SRS_MODE_MP_UNATT_I2C
		|=> multi_partition && ports_unattached && i2c_reset_init)
		else $error("unattached i2c mode decoded wrong");
	a_refclk_sel: assert property ( // [R11]
		release_evt |=> refclk_125_sel == $past(refclk_freq_select))
		else $error("reference frequency select not captured");
endmodule
`default_nettype wire

/* srs_strap_board.sv */
`timescale 1ns/10ps
`default_nettype none
module srs_strap_board
	import srs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic load,
	input wire logic [19:0] val,
	output logic [3:0] switch_operating_mode,
	output logic refclk_freq_select,
	output logic [1:0] port_clocking_select,
	output logic [3:0] stack2_lane_config,
	output logic [4:0] stack3_lane_config,
	output logic [1:0] slave_smbus_addr_straps,
	output logic reset_hold_request
);
	logic [19:0] strap_r;
	// resistors: levels move only when the board is re-strapped
	always @(posedge clk_sys) begin
		if (load) begin
			strap_r <= val;
		end
	end
	assign switch_operating_mode = strap_r[3:0];
	assign refclk_freq_select = strap_r[4];
	assign port_clocking_select = strap_r[6:5];
	assign stack2_lane_config = strap_r[11:8];
	assign stack3_lane_config = strap_r[16:12];
	assign slave_smbus_addr_straps = strap_r[18:17];
	assign reset_hold_request = strap_r[19];
endmodule
`default_nettype wire

/* srs_reset_ctrl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module srs_reset_ctrl_tb_top
	import srs_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic fundamental_reset_n = 1'b0;
	logic load = 1'b1;
	logic [19:0] val = 20'h00000;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic snap = 1'b0;
	logic rd_dp = 1'b0;
	logic [31:0] seed = 32'h0000_3949;
	logic [63:0] q_rd[$];
	logic [27:0] q_dec[$];
	logic [63:0] e;
	logic [31:0] r;
	logic [19:0] v;
	logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC, 4'hF, 4'h6};
	int mismatches = 0;
	int n_tests = 0;
	logic [3:0] switch_operating_mode;
	logic refclk_freq_select, reset_hold_request;
	logic [1:0] port_clocking_select, slave_smbus_addr_straps;
	logic [3:0] stack2_lane_config;
	logic [4:0] stack3_lane_config;
	logic hreadyout, hresp, core_reset_n, smbus_active, refclk_125_sel;
	logic [31:0] hrdata;
	logic [1:0] port_clk_mode, eeprom_jump;
	logic [3:0] stack2_cfg;
	logic [4:0] stack3_cfg;
	logic [6:0] smbus_slave_addr;
	logic multi_partition, init_from_eeprom, ports_unattached, i2c_reset_init, mode_invalid;
	logic [27:0] dec_now;

	always #10 clk_sys = ~clk_sys;

	srs_strap_board i_board (.clk_sys(clk_sys), .load(load), .val(val),
		.switch_operating_mode(switch_operating_mode), .refclk_freq_select(refclk_freq_select),
		.port_clocking_select(port_clocking_select), .stack2_lane_config(stack2_lane_config),
		.stack3_lane_config(stack3_lane_config),
		.slave_smbus_addr_straps(slave_smbus_addr_straps),
		.reset_hold_request(reset_hold_request));

	srs_reset_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.fundamental_reset_n(fundamental_reset_n), .reset_hold_request(reset_hold_request),
		.switch_operating_mode(switch_operating_mode), .refclk_freq_select(refclk_freq_select),
		.port_clocking_select(port_clocking_select), .stack2_lane_config(stack2_lane_config),
		.stack3_lane_config(stack3_lane_config),
		.slave_smbus_addr_straps(slave_smbus_addr_straps), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_reset_n(core_reset_n),
		.smbus_active(smbus_active), .refclk_125_sel(refclk_125_sel),
		.port_clk_mode(port_clk_mode), .stack2_cfg(stack2_cfg), .stack3_cfg(stack3_cfg),
		.smbus_slave_addr(smbus_slave_addr), .multi_partition(multi_partition),
		.init_from_eeprom(init_from_eeprom), .eeprom_jump(eeprom_jump),
		.ports_unattached(ports_unattached), .i2c_reset_init(i2c_reset_init),
		.mode_invalid(mode_invalid));

	assign dec_now = {refclk_125_sel, port_clk_mode, stack2_cfg, stack3_cfg, smbus_slave_addr,
		multi_partition, init_from_eeprom, eeprom_jump, ports_unattached, i2c_reset_init,
		mode_invalid, core_reset_n, smbus_active};

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] rnd;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [27:0] exp_dec(input logic [19:0] s, input logic run);
		logic mp, ee, un, i2c, inv;
		logic [1:0] jmp;
		mp = 1'b0;
		ee = 1'b0;
		un = 1'b0;
		i2c = 1'b0;
		inv = 1'b0;
		jmp = SRS_JUMP_NONE;
		case (s[3:0])
			SRS_MODE_SP: ;
			SRS_MODE_SP_EE: ee = 1'b1;
			SRS_MODE_SP_JUMP0: begin ee = 1'b1; jmp = SRS_JUMP_0; end
			SRS_MODE_SP_JUMP1: begin ee = 1'b1; jmp = SRS_JUMP_1; end
			SRS_MODE_MP_UNATT: begin mp = 1'b1; un = 1'b1; end
			SRS_MODE_MP_UNATT_EE: begin mp = 1'b1; un = 1'b1; ee = 1'b1; end
			SRS_MODE_MP_UNATT_I2C: begin mp = 1'b1; un = 1'b1; ee = 1'b1; i2c = 1'b1; end
			SRS_MODE_MP_DIS_EE: begin mp = 1'b1; ee = 1'b1; end
			default: inv = 1'b1;
		endcase
		// freq clock mode stacks slave address
		return {s[4], s[6:5], s[11:8], s[16:12], SRS_SMB_ADDR_BASE | {4'h0, s[18:17], 1'b0},
			mp, ee, jmp, un, i2c, inv, run, 1'b1};
	endfunction

	// bounded wait: hready is sampled before this edge's updates land
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			$display("ERROR t=%0t hready timeout seen=%h exp=%h", $time, hreadyout, 1'b1);
			end_sim;
		end
	endtask

	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] m);
		if (!wr) begin
			q_rd.push_back({m, d & m});
		end
		hsel <= 1'b1;
		htrans <= SRS_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
	endtask

	task automatic snap_chk(input logic [27:0] x);
		q_dec.push_back(x);
		snap <= 1'b1;
		@(posedge clk_sys);
		snap <= 1'b0;
	endtask

	// hold is strapped only early in reset: it must still be remembered at release
	task automatic run_cfg(input logic [19:0] s, input logic pulse);
		logic [27:0] x;
		x = exp_dec(s, !pulse);
		fundamental_reset_n <= 1'b0;
		val <= s | {pulse, 19'h0};
		load <= 1'b1;
		@(posedge clk_sys);
		val <= s;
		repeat (3) @(posedge clk_sys);
		load <= 1'b0;
		// slave address keeps its fixed base while the strap image is cleared
		snap_chk({12'h000, SRS_SMB_ADDR_BASE, 9'h000});
		fundamental_reset_n <= 1'b1;
		@(posedge clk_sys);
		snap_chk(x);
		xfer(1'b0, SRS_OFS_STRAP, {13'h0, s[18:0]}, 32'h0007_FFFF);
		xfer(1'b0, SRS_OFS_STAT, (pulse ? 32'h09 : 32'h1B) | {26'h0, x[2], 5'h0},
			32'h3B);
		// mode straps stay put after release, only the other straps move
		val <= {1'b0, ~s[18:4], s[3:0]};
		load <= 1'b1;
		@(posedge clk_sys);
		load <= 1'b0;
		repeat (2) @(posedge clk_sys);
		snap_chk(x);
		xfer(1'b0, SRS_OFS_STRAP, {13'h0, s[18:0]}, 32'h0007_FFFF);
		$display("test straps mode %h hold %0d done", s[3:0], pulse);
	endtask

	// watcher: read data is taken at the edge that ends the data phase
	always @(posedge clk_sys) begin
		if (rd_dp) begin
			e = q_rd.pop_front();
			check(hrdata & e[63:32], e[31:0]);
		end
		if (snap) begin
			check({4'h0, dec_now}, {4'h0, q_dec.pop_front()});
		end
		rd_dp <= hsel && hreadyout && htrans == SRS_HTRANS_NONSEQ && !hwrite;
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		xfer(1'b0, SRS_OFS_STAT, 32'h0, 32'h3B);
		for (int i = 0; i < 9; i++) begin
			r = rnd();
			v = {1'b0, r[18:8], 1'b0, r[6:4], codes[i]};
			run_cfg(v, 1'b0);
		end
		r = rnd();
		v = {1'b0, r[18:8], 1'b0, r[6:4], SRS_MODE_SP_EE};
		run_cfg(v, 1'b1);
		xfer(1'b0, SRS_OFS_CTL, 32'h1, 32'h1);
		xfer(1'b1, SRS_OFS_CTL, 32'h1, 32'h0);
		xfer(1'b0, SRS_OFS_CTL, 32'h1, 32'h1);
		xfer(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, 32'h0);
		xfer(1'b0, 32'h0000_0040, 32'h0, 32'hFFFF_FFFF);
		snap_chk(exp_dec(v, 1'b0));
		xfer(1'b1, SRS_OFS_CTL, 32'h0, 32'h0);
		@(posedge clk_sys);
		snap_chk(exp_dec(v, 1'b1));
		xfer(1'b0, SRS_OFS_STAT, 32'h1B, 32'h3B);
		xfer(1'b0, SRS_OFS_CTL, 32'h0, 32'h1);
		$display("test quasi release done");
		end_sim;
	end
endmodule
`default_nettype wire
